// ---- core/srd_readout.sv ----
// Result readout of a successive-approximation converter: conversion
// timing, output shift register, four output modes, data pin control.
// Assumes conv_result is valid from the converter core on clk_sys and
// that sclk and convert_start_sel_n come from the host, unrelated.
`timescale 1ns/10ps
`include "srd_map.svh"

module srd_readout #(
  parameter int RES_BITS = `SRD_RES_BITS,
  parameter int TCONV_NS = `SRD_TCONV_NS,
  parameter int AW       = `SRD_RING_AW
)(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                sclk,
  input  wire logic                convert_start_sel_n,
  input  wire logic                sdi,
  input  srd_pkg::srd_mode_t       out_mode,
  input  wire logic [RES_BITS-1:0] conv_result,
  output logic                     dout_o,
  output logic                     dout_oe,
  output logic                     conv_busy
);
  import srd_pkg::*;

  // Conversion time rounded up to whole system clocks
  localparam int CONV_CYC = (TCONV_NS + `SRD_CLK_NS - 1) / `SRD_CLK_NS;
  localparam int CW       = $clog2(CONV_CYC + 1);
  localparam int RW       = $clog2(RES_BITS + 2);
  localparam int FW       = $clog2(`SRD_CFG_EDGES + 1);

  srd_ring_if #(.AW(AW)) ring_if ();

  // Synchronisers
  logic                cnv_m_ff;
  logic                cnv_s_ff;
  logic                sclk_m_ff;
  logic                sclk_s_ff;
  logic [AW-1:0]       wg_m_ff;
  logic [AW-1:0]       wg_s_ff;
  logic                nxt_cnv_m;
  logic                nxt_cnv_s;
  logic                nxt_sclk_m;
  logic                nxt_sclk_s;
  logic [AW-1:0]       nxt_wg_m;
  logic [AW-1:0]       nxt_wg_s;

  // Readout state
  srd_state_t          state_ff;
  srd_state_t          nxt_state;
  logic [CW-1:0]       cnt_ff;
  logic [CW-1:0]       nxt_cnt;
  logic [RES_BITS-1:0] sh_ff;
  logic [RES_BITS-1:0] nxt_sh;
  logic [RW-1:0]       rem_ff;
  logic [RW-1:0]       nxt_rem;
  logic [RES_BITS-1:0] pend_ff;
  logic [RES_BITS-1:0] nxt_pend;
  logic                pend_vld_ff;
  logic                nxt_pend_vld;
  logic                bsy_flag_ff;
  logic                nxt_bsy_flag;
  logic                bsy_drv_ff;
  logic                nxt_bsy_drv;
  logic [FW-1:0]       cfg_ff;
  logic [FW-1:0]       nxt_cfg;
  logic [AW-1:0]       rd_ptr_ff;
  logic [AW-1:0]       nxt_rd_ptr;
  logic                cnv_prev_ff;
  logic                nxt_cnv_prev;
  logic                dout_ff;
  logic                nxt_dout;
  logic                oe_ff;
  logic                nxt_oe;
  logic                busy_ff;
  logic                nxt_busy;

  // Decoded conditions
  logic                daisy;
  logic                busy_mode;
  logic                sel_low;
  logic                cnv_rise;
  logic                cnv_fall;
  logic                conv_done;
  logic [AW-1:0]       wr_bin;
  logic                edge_take;
  logic                load_now;
  logic                pend_load;

  srd_edge_ring #(.AW(AW)) u_ring (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sclk    (sclk),
    .sdi     (sdi),
    .ring    (ring_if)
  );

  assign ring_if.rd_addr = nxt_rd_ptr;

  // Two flops on the select and serial clock pins and on the crossing gray pointer
  always_comb begin
    nxt_cnv_m  = convert_start_sel_n;
    nxt_cnv_s  = cnv_m_ff;
    nxt_sclk_m = sclk;
    nxt_sclk_s = sclk_m_ff;
    nxt_wg_m   = ring_if.wr_gray;
    nxt_wg_s   = wg_m_ff;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnv_m_ff  <= 1'b1;
      cnv_s_ff  <= 1'b1;
      sclk_m_ff <= 1'b0;
      sclk_s_ff <= 1'b0;
      wg_m_ff   <= '0;
      wg_s_ff   <= '0;
    end else begin
      cnv_m_ff  <= nxt_cnv_m;
      cnv_s_ff  <= nxt_cnv_s;
      sclk_m_ff <= nxt_sclk_m;
      sclk_s_ff <= nxt_sclk_s;
      wg_m_ff   <= nxt_wg_m;
      wg_s_ff   <= nxt_wg_s;
    end
  end

  // Mode decode, select edges and one recorded edge per clock
  always_comb begin
    daisy     = out_mode[`SRD_MODE_DAISY_BIT];
    busy_mode = out_mode[`SRD_MODE_BUSY_BIT];
    sel_low   = ~cnv_s_ff;
    cnv_rise  = cnv_s_ff & ~cnv_prev_ff;
    cnv_fall  = ~cnv_s_ff & cnv_prev_ff;
    conv_done = (state_ff == SRD_CONV) && (cnt_ff == '0);
    wr_bin[AW-1] = wg_s_ff[AW-1];
    for (int i = AW - 2; i >= 0; i--) begin
      wr_bin[i] = wr_bin[i+1] ^ wg_s_ff[i];
    end
    edge_take = (wr_bin != rd_ptr_ff);
    // In chip-select modes unread bits hold the new result back until they are gone
    load_now  = conv_done && (daisy || rem_ff == '0);
    pend_load = !conv_done && !daisy && !sel_low &&
                (state_ff == SRD_ACQ) && (rem_ff == '0) && pend_vld_ff;
  end

  // Conversion sequence, shifter and pin control
  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_sh       = sh_ff;
    nxt_rem      = rem_ff;
    nxt_pend     = pend_ff;
    nxt_pend_vld = pend_vld_ff;
    nxt_bsy_flag = bsy_flag_ff;
    nxt_bsy_drv  = bsy_drv_ff;
    nxt_cfg      = cfg_ff;
    nxt_cnv_prev = cnv_s_ff;
    nxt_rd_ptr   = rd_ptr_ff + {{(AW-1){1'b0}}, edge_take};

    // Start runs the full time; a second select rise is ignored meanwhile
    case (state_ff)
      SRD_ACQ: begin
        if (cnv_rise) begin
          nxt_state   = SRD_CONV;
          nxt_cnt     = CW'(CONV_CYC - 1);
          nxt_bsy_drv = 1'b0;
        end
      end
      SRD_CONV: begin
        if (cnt_ff == '0) begin
          nxt_state = SRD_ACQ;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = SRD_ACQ;
      end
    endcase

    // Falling edges: swallowed by a config write, else clear the busy flag or shift one bit while selected in acquisition
    if (edge_take) begin
      if (cfg_ff != '0) begin
        nxt_cfg = cfg_ff - 1'b1;
      end else if (sel_low && state_ff == SRD_ACQ) begin
        if (bsy_flag_ff) begin
          nxt_bsy_flag = 1'b0;
          if (!daisy) begin
            nxt_rem = rem_ff - 1'b1;
          end
        end else if (daisy) begin
          nxt_sh = {sh_ff[RES_BITS-2:0], ring_if.rd_bit};
        end else if (rem_ff != '0) begin
          nxt_sh  = {sh_ff[RES_BITS-2:0], 1'b0};
          nxt_rem = rem_ff - 1'b1;
        end
      end
    end

    // Clock high while select falls opens a configuration write
    if (cnv_fall && sclk_s_ff) begin
      nxt_cfg = FW'(`SRD_CFG_EDGES);
    end

    // Result load at completion, or leftover result once drained
    if (conv_done && !load_now) begin
      nxt_pend     = conv_result;
      nxt_pend_vld = 1'b1;
    end
    if (load_now || pend_load) begin
      nxt_sh       = load_now ? conv_result : pend_ff;
      nxt_bsy_flag = busy_mode;
      nxt_bsy_drv  = busy_mode && !daisy && load_now;
      nxt_pend_vld = 1'b0;
      if (daisy) begin
        nxt_rem = '0;
      end else if (busy_mode) begin
        nxt_rem = RW'(RES_BITS + 1);
      end else begin
        nxt_rem = RW'(RES_BITS);
      end
    end
    if (nxt_rem == '0) begin
      nxt_bsy_drv = 1'b0;
    end

    // Chip-select modes float when drained, or when deselected with no busy indicator driven
    nxt_oe = (nxt_state == SRD_ACQ) && (nxt_cfg == '0) &&
             (daisy || ((nxt_rem != '0) &&
                        (sel_low || nxt_bsy_drv)));
    nxt_dout = nxt_bsy_flag ? 1'b0 : nxt_sh[RES_BITS-1];
    nxt_busy = (nxt_state == SRD_CONV);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff    <= SRD_ACQ;
      cnt_ff      <= '0;
      sh_ff       <= '0;
      rem_ff      <= '0;
      pend_ff     <= '0;
      pend_vld_ff <= 1'b0;
      bsy_flag_ff <= 1'b0;
      bsy_drv_ff  <= 1'b0;
      cfg_ff      <= '0;
      rd_ptr_ff   <= '0;
      cnv_prev_ff <= 1'b1;
      dout_ff     <= 1'b0;
      oe_ff       <= 1'b0;
      busy_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      sh_ff       <= nxt_sh;
      rem_ff      <= nxt_rem;
      pend_ff     <= nxt_pend;
      pend_vld_ff <= nxt_pend_vld;
      bsy_flag_ff <= nxt_bsy_flag;
      bsy_drv_ff  <= nxt_bsy_drv;
      cfg_ff      <= nxt_cfg;
      rd_ptr_ff   <= nxt_rd_ptr;
      cnv_prev_ff <= nxt_cnv_prev;
      dout_ff     <= nxt_dout;
      oe_ff       <= nxt_oe;
      busy_ff     <= nxt_busy;
    end
  end

  // Pins lag the serial clock by the synchroniser depth plus one output register
  assign dout_o    = dout_ff;
  assign dout_oe   = oe_ff;
  assign conv_busy = busy_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  start_floats_a: assert property (
    (state_ff == SRD_ACQ) && cnv_rise |=>
      !dout_oe && conv_busy && (state_ff == SRD_CONV))
    else $error("start did not float the output");

  conv_runs_a: assert property (
    (state_ff == SRD_CONV) && (cnt_ff != '0) |=>
      (state_ff == SRD_CONV) && (cnt_ff == $past(cnt_ff) - 1'b1))
    else $error("conversion ended early");

  msb_at_end_a: assert property (
    conv_done && (out_mode == `SRD_MODE_CS_NOBUSY) && sel_low &&
    (rem_ff == '0) && (nxt_cfg == '0) |=>
      dout_oe && (dout_o == $past(conv_result[RES_BITS-1])))
    else $error("MSB not driven at conversion end");

  cs_shift_a: assert property (
    edge_take && !daisy && sel_low && (state_ff == SRD_ACQ) &&
    (cfg_ff == '0) && !bsy_flag_ff && (rem_ff > 1) && !conv_done |=>
      (rem_ff == $past(rem_ff) - 1'b1) &&
      (dout_o == $past(sh_ff[RES_BITS-2])))
    else $error("chip-select edge did not shift one bit");

  cs_float_a: assert property (
    !daisy && ((nxt_rem == '0) || (!sel_low && !nxt_bsy_drv)) |=> !dout_oe)
    else $error("output driven after last bit or deselect");

  busy_low_a: assert property (
    conv_done && (out_mode == `SRD_MODE_CS_BUSY) && (rem_ff == '0) &&
    (nxt_cfg == '0) |=> dout_oe && !dout_o && bsy_drv_ff)
    else $error("busy indicator not driven low");

  busy_count_a: assert property (
    conv_done && !daisy && busy_mode && (rem_ff == '0) |=>
      (rem_ff == RW'(RES_BITS + 1)) && bsy_flag_ff)
    else $error("busy readout not nineteen edges long");

  chain_shift_a: assert property (
    edge_take && daisy && sel_low && (state_ff == SRD_ACQ) &&
    (cfg_ff == '0) && !bsy_flag_ff && !conv_done |=>
      (sh_ff[0] == $past(ring_if.rd_bit)) &&
      (sh_ff[RES_BITS-1:1] == $past(sh_ff[RES_BITS-2:0])))
    else $error("daisy edge did not pass the input bit");

  chain_busy_a: assert property (
    conv_done && (out_mode == `SRD_MODE_DC_BUSY) && (nxt_cfg == '0) |=>
      (state_ff == SRD_ACQ) && dout_oe && !dout_o && bsy_flag_ff)
    else $error("daisy busy indicator missing");

  cfg_entry_a: assert property (
    cnv_fall && sclk_s_ff |=> (cfg_ff == FW'(`SRD_CFG_EDGES)))
    else $error("configuration write not entered");

  leftover_a: assert property (
    conv_done && !daisy && (rem_ff != '0) |=>
      pend_vld_ff && (rem_ff == $past(rem_ff)) &&
      (sh_ff == $past(sh_ff)))
    else $error("leftover bits overwritten by new result");

endmodule : srd_readout

// ---- core/srd_map.svh ----
// Constants of the serial result readout: widths, mode codes, timing.
// Assumes inclusion by bare name from the readout modules.
`ifndef SRD_MAP_SVH
`define SRD_MAP_SVH

`define SRD_RES_BITS       18
`define SRD_CFG_EDGES      8
`define SRD_CLK_NS         20
`define SRD_TCONV_NS       1000
`define SRD_RING_AW        6

`define SRD_MODE_CS_NOBUSY 2'h0
`define SRD_MODE_CS_BUSY   2'h1
`define SRD_MODE_DC_NOBUSY 2'h2
`define SRD_MODE_DC_BUSY   2'h3
`define SRD_MODE_DAISY_BIT 1
`define SRD_MODE_BUSY_BIT  0

`endif

// ---- core/srd_pkg.sv ----
// Types shared by the serial result readout.
// Assumes srd_map.svh supplies the numeric constants.
package srd_pkg;

  // Output mode field: bit 1 daisy chain, bit 0 busy indicator
  typedef logic [1:0] srd_mode_t;

  // Converter phase
  typedef enum {SRD_ACQ, SRD_CONV} srd_state_t;

endpackage : srd_pkg

// ---- core/srd_ring_if.sv ----
// Carrier between the readout core and its serial-clock edge ring.
// Assumes the gray write pointer is synchronised by the reader.
`timescale 1ns/10ps
interface srd_ring_if #(
  parameter int AW = 6
);
  logic [AW-1:0] wr_gray;
  logic [AW-1:0] rd_addr;
  logic          rd_bit;

  modport ring (output wr_gray, output rd_bit, input rd_addr);
  modport core (input wr_gray, input rd_bit, output rd_addr);
endinterface : srd_ring_if

// ---- core/srd_edge_ring.sv ----
// Serial-clock side: records the data input at every falling edge.
// Assumes the reader follows the gray pointer through two flip-flops.
`timescale 1ns/10ps
module srd_edge_ring #(
  parameter int AW = 6
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdi,
  srd_ring_if.ring ring
);
  import srd_pkg::*;

  localparam int DEPTH = 1 << AW;

  logic [AW-1:0] wr_bin_ff;
  logic [AW-1:0] wr_gray_ff;
  logic [AW-1:0] nxt_wr_bin;
  logic [AW-1:0] nxt_wr_gray;
  logic          mem [DEPTH];
  logic          rd_bit_ff;

  // One entry per falling edge; pointer goes out gray coded
  always_comb begin
    nxt_wr_bin  = wr_bin_ff + 1'b1;
    nxt_wr_gray = nxt_wr_bin ^ (nxt_wr_bin >> 1);
  end

  // Entry written on the same edge that moves its pointer; the reader sees that pointer two flops later
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      wr_bin_ff  <= '0;
      wr_gray_ff <= '0;
    end else begin
      wr_bin_ff  <= nxt_wr_bin;
      wr_gray_ff <= nxt_wr_gray;
    end
  end

  always_ff @(negedge sclk) begin
    mem[wr_bin_ff] <= sdi;
  end

  // Registered read on the system clock
  always_ff @(posedge clk_sys) begin
    rd_bit_ff <= mem[ring.rd_addr];
  end

  assign ring.wr_gray = wr_gray_ff;
  assign ring.rd_bit  = rd_bit_ff;

endmodule : srd_edge_ring

// ---- sim/srd_host_model.sv ----
// Host model: select line, serial clock pulses, upstream chain data.
// Assumes the bench calls its tasks just after a falling clk_sys edge.
`timescale 1ns/10ps
module srd_host_model (
  input  wire logic clk_sys,
  output logic      sclk,
  output logic      convert_start_sel_n,
  output logic      sdi
);
  // Clock idles low so a select fall outside cfg_fall never means a config write
  initial begin
    sclk = 1'b0;
    convert_start_sel_n = 1'b1;
    sdi = 1'b0;
  end

  // Select level; the bench times it off the sampling edge
  task automatic sel(input logic lvl);
    convert_start_sel_n = lvl;
  endtask : sel

  // One 7.5 ns high clock pulse, then the clock stands still low
  task automatic pulse(input logic d);
    #3 sdi = d;
    sclk = 1'b1;
    #7.5 sclk = 1'b0;
    #1 sdi = ~d; // Upstream released: no stale level
  endtask : pulse

  // Select falls while the clock is high; the clock stays high past a
  // system edge so both synchronisers see the pair together
  task automatic cfg_fall;
    sclk = 1'b1;
    #4 convert_start_sel_n = 1'b0;
    #12 sclk = 1'b0;
  endtask : cfg_fall

  // Edges per readout from mode and chain length
  function automatic int n_edges(input logic busy, input int chain);
    return 18 * chain + (busy ? 1 : 0);
  endfunction : n_edges
endmodule : srd_host_model

// ---- sim/srd_readout_tb.sv ----
// Self-checking bench of the serial result readout, all four modes.
// Assumes the host model drives select, serial clock and chain input.
`timescale 1ns/10ps
`include "srd_map.svh"
module srd_readout_tb;
  import srd_pkg::*;
  localparam int TC = 200;
  localparam int CC = TC / `SRD_CLK_NS;
  localparam int RB = `SRD_RES_BITS;
  logic          clk_sys;
  logic          rst;
  logic          sclk;
  logic          sel_n;
  logic          sdi;
  logic          dout_o;
  logic          dout_oe;
  logic          conv_busy;
  srd_mode_t     out_mode;
  logic [RB-1:0] res;
  int            err_total;
  int            cmp_count;

  // Short conversion keeps the run brief
  srd_readout #(.TCONV_NS(TC)) uut (
    .clk_sys(clk_sys), .rst(rst), .sclk(sclk),
    .convert_start_sel_n(sel_n), .sdi(sdi), .out_mode(out_mode),
    .conv_result(res), .dout_o(dout_o), .dout_oe(dout_oe),
    .conv_busy(conv_busy));

  srd_host_model host (
    .clk_sys(clk_sys), .sclk(sclk),
    .convert_start_sel_n(sel_n), .sdi(sdi));

  // System clock, 20 ns
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [RB-1:0] exp,
                     input logic [RB-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic give_up(input string nm);
    err_total++;
    $display("[ERR] %s expected done seen timeout", nm);
    stop_test();
  endtask : give_up

  task automatic do_reset(input srd_mode_t m);
    out_mode = m;
    rst = 1'b1;
    step(3);
    rst = 1'b0;
    step(3);
  endtask : do_reset

  // Start a conversion and time its busy window
  task automatic convert(input logic low_during);
    int n;
    host.sel(1'b0);
    step(2);
    host.sel(1'b1);
    n = 0;
    while (conv_busy !== 1'b1 && n < 8) begin
      step(1);
      n++;
    end
    if (conv_busy !== 1'b1) give_up("busy rise");
    chk("oe in conv", 0, dout_oe);
    if (low_during) host.sel(1'b0);
    n = 0;
    while (conv_busy === 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    if (n >= 100) give_up("busy fall");
    chk("conv cycles", CC, n);
    step(2);
  endtask : convert

  // One serial edge, then look at the pin once it has settled
  task automatic edge_chk(input logic d, input logic oe, input logic v,
                          input string nm);
    host.pulse(d);
    step(8);
    chk({nm, " oe"}, oe, dout_oe);
    if (oe) chk(nm, v, dout_o);
  endtask : edge_chk

  task automatic sc_reset;
    rst = 1'b1;
    step(2);
    chk("rst oe", 0, dout_oe);
    chk("rst busy", 0, conv_busy);
  endtask : sc_reset

  task automatic sc_cs_plain;
    do_reset(`SRD_MODE_CS_NOBUSY);
    res = 18'h2b5c9;
    convert(1'b1);
    chk("held msb oe", 1, dout_oe);
    chk("held msb", res[RB-1], dout_o);
    for (int i = RB - 2; i >= 0; i--)
      edge_chk(1'b0, 1'b1, res[i], "cs bit");
    edge_chk(1'b0, 1'b0, 1'b0, "cs last");
  endtask : sc_cs_plain

  // Deselect mid-read, then the leftover bits come first
  task automatic sc_cs_abort;
    logic [RB-1:0] old;
    do_reset(`SRD_MODE_CS_NOBUSY);
    res = 18'h1c3a7;
    old = res;
    convert(1'b0);
    chk("idle oe", 0, dout_oe);
    host.sel(1'b0);
    step(4);
    chk("sel msb", old[RB-1], dout_o);
    for (int i = RB - 2; i >= RB - 4; i--)
      edge_chk(1'b0, 1'b1, old[i], "part bit");
    res = 18'h0e4d2;
    convert(1'b0);
    host.sel(1'b0);
    step(4);
    chk("left bit", old[RB-4], dout_o);
    edge_chk(1'b0, 1'b1, old[RB-5], "left next");
  endtask : sc_cs_abort

  task automatic sc_cs_busy;
    do_reset(`SRD_MODE_CS_BUSY);
    res = 18'h30f1e;
    convert(1'b0);
    chk("done oe", 1, dout_oe);
    chk("done low", 0, dout_o);
    step(3);
    host.sel(1'b0);
    step(4);
    for (int i = RB - 1; i >= 0; i--)
      edge_chk(1'b0, 1'b1, res[i], "busy bit");
    edge_chk(1'b0, 1'b0, 1'b0, "busy last");
  endtask : sc_cs_busy

  // Two-deep chain: own bits, then the upstream word
  task automatic sc_daisy;
    logic [RB-1:0] up;
    int ne;
    do_reset(`SRD_MODE_DC_NOBUSY);
    res = 18'h25a96;
    up = 18'h1b34d;
    ne = host.n_edges(1'b0, 2);
    convert(1'b0);
    chk("dc oe", 1, dout_oe);
    chk("dc msb", res[RB-1], dout_o);
    host.sel(1'b0);
    step(4);
    for (int k = 1; k <= ne; k++)
      edge_chk(k <= RB ? up[RB-k] : 1'b0, 1'b1,
               k < RB ? res[RB-1-k] :
               (k < 2 * RB ? up[2*RB-1-k] : 1'b0), "chain");
  endtask : sc_daisy

  task automatic sc_daisy_busy;
    int ne;
    do_reset(`SRD_MODE_DC_BUSY);
    res = 18'h3c5e1;
    ne = host.n_edges(1'b1, 1);
    convert(1'b0);
    chk("dcb oe", 1, dout_oe);
    chk("dcb flag", 0, dout_o);
    chk("dcb acq", 0, conv_busy);
    step(3);
    host.sel(1'b0);
    step(4);
    for (int k = 1; k <= ne; k++)
      edge_chk(1'b0, 1'b1, k < ne ? res[RB-k] : 1'b0, "dcb bit");
  endtask : sc_daisy_busy

  // Clock high at select fall: edges go to configuration
  task automatic sc_cfg;
    do_reset(`SRD_MODE_CS_NOBUSY);
    res = 18'h0a5f3;
    convert(1'b0);
    host.cfg_fall();
    step(4);
    chk("cfg oe", 0, dout_oe);
    for (int k = 0; k < 6; k++)
      edge_chk(1'b0, 1'b0, 1'b0, "cfg edge");
    // Eighth swallowed edge ends the write; the result is still whole
    edge_chk(1'b0, 1'b1, res[RB-1], "cfg done");
    edge_chk(1'b0, 1'b1, res[RB-2], "cfg read");
  endtask : sc_cfg

  initial begin
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    out_mode = `SRD_MODE_CS_NOBUSY;
    res = '0;
    sc_reset();
    sc_cs_plain();
    sc_cs_abort();
    sc_cs_busy();
    sc_daisy();
    sc_daisy_busy();
    sc_cfg();
    stop_test();
  end
endmodule : srd_readout_tb
